// File: hdl/cgr_pkg.sv
// Package for the character OLED reset-state and user-glyph slot block.
// Assumes a single 40 MHz clock domain and a plain strobe register port.
package cgr_pkg;

	// Register byte addresses
	localparam logic [7:0] CGR_ADDR_DISP    = 8'h00;
	localparam logic [7:0] CGR_ADDR_CONTR   = 8'h04;
	localparam logic [7:0] CGR_ADDR_EXT     = 8'h08;
	localparam logic [7:0] CGR_ADDR_SLOT    = 8'h0c;
	localparam logic [7:0] CGR_ADDR_GADDR   = 8'h10;
	localparam logic [7:0] CGR_ADDR_GDATA   = 8'h14;
	localparam logic [7:0] CGR_ADDR_START   = 8'h18;

	// Display control field positions
	localparam int CGR_BIT_DISP_ON  = 0;
	localparam int CGR_BIT_CURSOR   = 1;
	localparam int CGR_BIT_BLINK    = 2;
	localparam int CGR_BIT_FONT     = 3;

	// Reset values
	localparam logic [3:0] CGR_RST_DISP    = 4'h0;
	localparam logic [7:0] CGR_RST_CONTR   = 8'h7f;
	localparam logic       CGR_RST_EXT     = 1'b0;
	localparam logic [1:0] CGR_RST_SLOT    = 2'h0;
	localparam logic [5:0] CGR_RST_GADDR   = 6'h00;
	localparam logic [6:0] CGR_RST_START   = 7'h00;

	// Glyph RAM geometry: eight glyphs of eight rows
	localparam int CGR_GRAM_DEPTH = 64;
	localparam int CGR_ROW_W      = 8;

	// Slot select settings
	typedef enum logic [1:0] {
		CGR_SLOT_8 = 2'h0,
		CGR_SLOT_6 = 2'h1,
		CGR_SLOT_4 = 2'h2,
		CGR_SLOT_0 = 2'h3
	} cgr_slot_t;

endpackage

// File: hdl/cgr_glyph_map.sv
// Character code router deciding user glyph RAM versus glyph ROM.
// Assumes code and slot setting come from the same clock domain.
`timescale 1ns/1ps
module cgr_glyph_map (
	// Character code and slot setting
	input  wire logic [7:0] code_i,
	input  wire logic [1:0] slot_sel_i,
	// Routing result
	output logic            use_ram_o,
	output logic [2:0]      slot_o
);

	// Number of codes from 00h upward served by glyph RAM
	function automatic logic [3:0] slot_count(input logic [1:0] sel);
		unique case (cgr_pkg::cgr_slot_t'(sel))
			cgr_pkg::CGR_SLOT_8: slot_count = 4'h8;
			cgr_pkg::CGR_SLOT_6: slot_count = 4'h6;
			cgr_pkg::CGR_SLOT_4: slot_count = 4'h4;
			cgr_pkg::CGR_SLOT_0: slot_count = 4'h0;
		endcase
	endfunction

	// slot gate; codes above 07h never reach glyph RAM
	always_comb begin
		use_ram_o = (code_i[7:3] == 5'h00) && ({1'b0, code_i[2:0]} < slot_count(slot_sel_i));
		slot_o    = code_i[2:0];
	end

endmodule

// File: hdl/cgr_reset_state.sv
// Top of the reset-state and user glyph block: settings registers, glyph RAM
// with auto-incrementing address and the character code router.
// Assumes the register master shares CLK_I; RESET_I is the inverted
// active-low reset pin, already synchronised to release on CLK_I.
`timescale 1ns/1ps
module cgr_reset_state (
	// Clock and reset
	input  wire logic       CLK_I,
	input  wire logic       RESET_I,
	// Register port
	input  wire logic [7:0] ADDR_I,
	input  wire logic [7:0] WDATA_I,
	input  wire logic       WR_I,
	input  wire logic       RD_I,
	output logic      [7:0] RDATA_O,
	// Character lookup
	input  wire logic [7:0] CHAR_CODE_I,
	input  wire logic [2:0] CHAR_ROW_I,
	output logic            USE_RAM_O,
	output logic      [7:0] GLYPH_ROW_O,
	// Settings seen by the display engine
	output logic            DISP_ON_O,
	output logic            CURSOR_ON_O,
	output logic            BLINK_ON_O,
	output logic            FONT_TALL_O,
	output logic      [7:0] CONTRAST_O,
	output logic            EXT_CMD_EN_O,
	output logic      [6:0] START_ADDR_O
);

	// Settings state
	logic [3:0] disp_r;
	logic [3:0] disp_nxt;
	logic [7:0] contr_r;
	logic [7:0] contr_nxt;
	logic       ext_r;
	logic       ext_nxt;
	logic [1:0] slot_r;
	logic [1:0] slot_nxt;
	logic [5:0] gaddr_r;
	logic [5:0] gaddr_nxt;
	logic [6:0] start_r;
	logic [6:0] start_nxt;

	// Bus answer state
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;

	// Lookup output state
	logic       use_ram_r;
	logic       use_ram_nxt;
	logic [7:0] grow_r;
	logic [7:0] grow_nxt;

	// Glyph RAM, no reset: contents are undefined after power-up
	logic [7:0] gram [0:cgr_pkg::CGR_GRAM_DEPTH-1];
	logic [7:0] gram_rd;

	// Router result
	logic       map_use_ram;
	logic [2:0] map_slot;

	logic       wr_gdata;

	// Decoding of the write strobe to glyph data
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
		hit = (a == ref_a);
	endfunction

	assign wr_gdata = WR_I && hit(ADDR_I, cgr_pkg::CGR_ADDR_GDATA);

	cgr_glyph_map u_map (
		.code_i     (CHAR_CODE_I),
		.slot_sel_i (slot_r),
		.use_ram_o  (map_use_ram),
		.slot_o     (map_slot)
	);

	// Settings next state from register writes
	always_comb begin
		disp_nxt  = disp_r;
		contr_nxt = contr_r;
		ext_nxt   = ext_r;
		slot_nxt  = slot_r;
		gaddr_nxt = gaddr_r;
		start_nxt = start_r;
		if (WR_I) begin
			if (hit(ADDR_I, cgr_pkg::CGR_ADDR_DISP)) begin
				disp_nxt = WDATA_I[3:0];
			end
			if (hit(ADDR_I, cgr_pkg::CGR_ADDR_CONTR)) begin
				contr_nxt = WDATA_I;
			end
			if (hit(ADDR_I, cgr_pkg::CGR_ADDR_EXT)) begin
				ext_nxt = WDATA_I[0];
			end
			if (hit(ADDR_I, cgr_pkg::CGR_ADDR_SLOT)) begin
				slot_nxt = WDATA_I[1:0];
			end
			if (hit(ADDR_I, cgr_pkg::CGR_ADDR_GADDR)) begin
				gaddr_nxt = WDATA_I[5:0];
			end
			if (hit(ADDR_I, cgr_pkg::CGR_ADDR_START)) begin
				start_nxt = WDATA_I[6:0];
			end
		end
		// address step on data write, wraps at 63
		if (wr_gdata) begin
			gaddr_nxt = gaddr_r + 6'h01;
		end
	end

	// Settings registers
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			disp_r  <= cgr_pkg::CGR_RST_DISP;
			start_r <= cgr_pkg::CGR_RST_START;
			gaddr_r <= cgr_pkg::CGR_RST_GADDR;
			contr_r <= cgr_pkg::CGR_RST_CONTR;
			ext_r   <= cgr_pkg::CGR_RST_EXT;
			slot_r  <= cgr_pkg::CGR_RST_SLOT;
		end else begin
			disp_r  <= disp_nxt;
			start_r <= start_nxt;
			gaddr_r <= gaddr_nxt;
			contr_r <= contr_nxt;
			ext_r   <= ext_nxt;
			slot_r  <= slot_nxt;
		end
	end

	// Glyph RAM write port at the current address
	always_ff @(posedge CLK_I) begin
		if (wr_gdata) begin
			gram[gaddr_r] <= WDATA_I;
		end
	end

	// Glyph RAM reads: bus read uses the address counter
	assign gram_rd = gram[gaddr_r];

	// Read data, one cycle after the strobe and zero otherwise
	always_comb begin
		rdata_nxt = 8'h00;
		if (RD_I) begin
			unique case (ADDR_I)
				cgr_pkg::CGR_ADDR_DISP:  rdata_nxt = {4'h0, disp_r};
				cgr_pkg::CGR_ADDR_CONTR: rdata_nxt = contr_r;
				cgr_pkg::CGR_ADDR_EXT:   rdata_nxt = {7'h00, ext_r};
				cgr_pkg::CGR_ADDR_SLOT:  rdata_nxt = {6'h00, slot_r};
				cgr_pkg::CGR_ADDR_GADDR: rdata_nxt = {2'h0, gaddr_r};
				cgr_pkg::CGR_ADDR_GDATA: rdata_nxt = gram_rd;
				cgr_pkg::CGR_ADDR_START: rdata_nxt = {1'b0, start_r};
				default:                 rdata_nxt = 8'h00;
			endcase
		end
	end

	// lookup through glyph RAM only for enabled slots
	always_comb begin
		use_ram_nxt = map_use_ram;
		grow_nxt    = map_use_ram ? gram[{map_slot, CHAR_ROW_I}] : 8'h00;
	end

	// Bus and lookup output registers
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			rdata_r   <= 8'h00;
			use_ram_r <= 1'b0;
			grow_r    <= 8'h00;
		end else begin
			rdata_r   <= rdata_nxt;
			use_ram_r <= use_ram_nxt;
			grow_r    <= grow_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign RDATA_O      = rdata_r;
	assign USE_RAM_O    = use_ram_r;
	assign GLYPH_ROW_O  = grow_r;
	assign DISP_ON_O    = disp_r[cgr_pkg::CGR_BIT_DISP_ON];
	assign CURSOR_ON_O  = disp_r[cgr_pkg::CGR_BIT_CURSOR];
	assign BLINK_ON_O   = disp_r[cgr_pkg::CGR_BIT_BLINK];
	assign FONT_TALL_O  = disp_r[cgr_pkg::CGR_BIT_FONT];
	assign CONTRAST_O   = contr_r;
	assign EXT_CMD_EN_O = ext_r;
	assign START_ADDR_O = start_r;

endmodule

// File: tb/cgr_checker.sv
// Assertions on the ports of the reset-state and glyph block.
// Assumes one clock domain; bound to every instance of the top.
`timescale 1ns/1ps
module cgr_checker (
	// Clock, reset and register port
	input wire logic	CLK_I,
	input wire logic	RESET_I,
	input wire logic [7:0]	ADDR_I,
	input wire logic [7:0]	WDATA_I,
	input wire logic	WR_I,
	// Lookup and settings
	input wire logic [7:0]	CHAR_CODE_I,
	input wire logic	USE_RAM_O,
	input wire logic	DISP_ON_O,
	input wire logic	CURSOR_ON_O,
	input wire logic	BLINK_ON_O,
	input wire logic	FONT_TALL_O,
	input wire logic [7:0]	CONTRAST_O,
	input wire logic	EXT_CMD_EN_O,
	input wire logic [6:0]	START_ADDR_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RESET_I);
	// Defaults at release, then contrast, extension and start address move only on their own write
	chk_reset_disp: assert property ($fell(RESET_I) |-> !DISP_ON_O && !CURSOR_ON_O
		&& !BLINK_ON_O && !FONT_TALL_O && START_ADDR_O == 7'h00) else $error("display defaults wrong");
	chk_reset_lvl: assert property ($fell(RESET_I) |-> CONTRAST_O == 8'h7f && !EXT_CMD_EN_O)
		else $error("contrast or extension default wrong");
	chk_contr_write: assert property (WR_I && ADDR_I == 8'h04 |=> CONTRAST_O == $past(WDATA_I))
		else $error("contrast write lost");
	chk_contr_hold: assert property (!(WR_I && ADDR_I == 8'h04) |=> $stable(CONTRAST_O))
		else $error("contrast moved without write");
	chk_ext_write: assert property (WR_I && ADDR_I == 8'h08 |=> EXT_CMD_EN_O == $past(WDATA_I[0]))
		else $error("extension write lost");
	chk_ext_hold: assert property (!(WR_I && ADDR_I == 8'h08) |=> $stable(EXT_CMD_EN_O))
		else $error("extension moved without write");
	chk_rom_codes: assert property (CHAR_CODE_I[7:3] != 5'h00 |=> !USE_RAM_O)
		else $error("high code served from ram");
	chk_start_hold: assert property (!(WR_I && ADDR_I == 8'h18) |=> $stable(START_ADDR_O))
		else $error("start address moved");
endmodule

bind cgr_reset_state cgr_checker chk (.*);

// File: tb/cgr_host_model.sv
// Host side model: owns the reset line of the block.
// Assumes the bench asks for each reset through pulse.
`timescale 1ns/1ps
module cgr_host_model (
	// Clock in, reset out
	input wire logic	clk_i,
	output logic	rst_o
);
	// Reset is active from time zero until the first pulse ends
	initial rst_o = 1'b1;
	task automatic pulse();
		@(negedge clk_i);
		rst_o <= 1'b1;
		repeat (10) @(posedge clk_i);
		rst_o <= 1'b0;
	endtask
endmodule

// File: tb/cgr_reset_state_bench.sv
// Self-checking bench for the reset-state and glyph block.
// Assumes the host model owns reset; bus driven after rising edges.
`timescale 1ns/1ps
module cgr_reset_state_bench;
	logic	clk = 1'b0;
	logic [7:0]	addr = 8'h00, wdata = 8'h00, code = 8'h00, rdata, grow, contr, v;
	logic [7:0]	mem [64];
	logic [6:0]	start;
	logic [2:0]	row = 3'h0;
	logic	wr = 1'b0, rd = 1'b0, rst, use_ram, don, cur, blk, font, ext;
	int	num_errors = 0, check_count = 0, cnt = 0, nsel = 0;
	logic [31:0]	seed = 32'h0f0ab919;
	// Clock at 40 MHz
	always #12.5 clk = ~clk;
	cgr_host_model host (.clk_i(clk), .rst_o(rst));
	cgr_reset_state dut (.CLK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
		.RDATA_O(rdata), .CHAR_CODE_I(code), .CHAR_ROW_I(row), .USE_RAM_O(use_ram), .GLYPH_ROW_O(grow),
		.DISP_ON_O(don), .CURSOR_ON_O(cur), .BLINK_ON_O(blk), .FONT_TALL_O(font), .CONTRAST_O(contr),
		.EXT_CMD_EN_O(ext), .START_ADDR_O(start));
	// Random source and compare helpers
	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		check_count++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	// Bus tasks keep a gap so a strobe is never assigned twice at one edge
	task automatic wr_reg(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		if (a == 8'h14) begin
			mem[cnt] = d;
			cnt = (cnt + 1) % 64;
		end
	endtask
	task automatic rd_reg(logic [7:0] a, logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk("rdata", rdata, e);
		// Read data stands one cycle only, then returns to zero
		@(negedge clk);
		chk("rdata_idle", rdata, 8'h00);
	endtask
	// Lookup: codes below the slot count read glyph ram, others give zero
	task automatic look(logic [7:0] c, logic [7:0] r);
		int n;
		logic u;
		n = nsel == 0 ? 8 : nsel == 1 ? 6 : nsel == 2 ? 4 : 0;
		u = c < n;
		@(posedge clk);
		code <= c;
		row <= r[2:0];
		@(posedge clk);
		@(negedge clk);
		chk("use_ram", {7'h00, use_ram}, {7'h00, u});
		chk("glyph_row", grow, u ? mem[{c[2:0], r[2:0]}] : 8'h00);
	endtask
	task automatic defaults();
		@(negedge clk);
		chk("disp", {4'h0, font, blk, cur, don}, 8'h00);
		chk("start", {1'b0, start}, 8'h00);
		chk("contrast", contr, 8'h7f);
		chk("ext", {7'h00, ext}, 8'h00);
	endtask
	task automatic conclude();
		if (num_errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Main sequence
	initial begin
		host.pulse();
		defaults();
		rd_reg(8'h04, 8'h7f);
		rd_reg(8'h1c, 8'h00);
		for (int i = 0; i < 64; i++) wr_reg(8'h14, xs());
		rd_reg(8'h14, mem[0]);
		for (int s = 0; s < 4; s++) begin
			nsel = s;
			wr_reg(8'h0c, s[7:0]);
			for (int k = 0; k < 24; k++) look(xs() & 8'h8f, xs());
		end
		v = xs();
		wr_reg(8'h04, v);
		rd_reg(8'h04, v);
		wr_reg(8'h08, 8'h01);
		wr_reg(8'h00, 8'h0f);
		wr_reg(8'h18, 8'h25);
		@(negedge clk);
		chk("disp_set", {4'h0, font, blk, cur, don}, 8'h0f);
		chk("ext_set", {7'h00, ext}, 8'h01);
		chk("start_set", {1'b0, start}, 8'h25);
		host.pulse();
		cnt = 0;
		nsel = 0;
		defaults();
		wr_reg(8'h14, 8'h5a);
		look(8'h00, 8'h00);
		conclude();
	end
	// Watchdog well past the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		conclude();
	end
endmodule
